// *** rtl/ext_exec.sv ***
// Execute logic for add-to-pointer, add-and-return and call-via-accumulator
`include "ext_exec_regs.svh"
`default_nettype none
module ext_exec #(
    parameter int PTR_W = 12,
    parameter int PC_W = 21
) (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    // Instruction word, presented in Q1
    input wire logic i_instr_valid,
    input wire logic [15:0] i_instr,
    input wire logic i_extended_set_enable_bit,
    // Core state
    input wire logic [PTR_W-1:0] i_file_select_pointer_0,
    input wire logic [PTR_W-1:0] i_file_select_pointer_1,
    input wire logic [PTR_W-1:0] i_stack_frame_pointer,
    input wire logic [PC_W-1:0] i_pc,
    input wire logic [PC_W-1:0] i_top_of_return_stack,
    input wire logic [7:0] i_accumulator_reg,
    input wire logic [7:0] i_counter_latch_high,
    input wire logic [PC_W-17:0] i_counter_latch_upper,
    // Pointer write
    output logic o_ptr_we,
    output logic [1:0] o_ptr_sel,
    output logic [PTR_W-1:0] o_ptr_data,
    // Return stack and program counter
    output logic o_stack_push,
    output logic [PC_W-1:0] o_stack_push_addr,
    output logic o_stack_pop,
    output logic o_pc_load,
    output logic [PC_W-1:0] o_pc_value,
    // Status
    output logic o_nop_cycle,
    output ext_exec_pkg::quarter_t o_quarter
);
    import ext_exec_pkg::*;

    typedef struct packed {
        op_e op;
        logic [1:0] sel;
        logic [5:0] lit;
        logic [PTR_W-1:0] base;
        logic [7:0] acc;
        logic nop_next;
        logic nop_cycle;
        logic ptr_we;
        logic [1:0] ptr_sel;
        logic [PTR_W-1:0] ptr_data;
        logic push;
        logic [PC_W-1:0] push_addr;
        logic pop;
        logic pc_load;
        logic [PC_W-1:0] pc_value;
    } exec_s;

    exec_s q_q;
    exec_s d_d;
    quarter_if ph ();

    quarter_gen u_quarter_gen (
        .i_ref_clk(i_ref_clk),
        .i_arst_n(i_arst_n),
        .ph(ph)
    );

    logic dec_q1;
    assign dec_q1 = ph.q[`EXT_Q1] && i_instr_valid && i_extended_set_enable_bit && !q_q.nop_next;

    always_comb begin
        d_d = q_q;
        d_d.ptr_we = 1'b0;
        d_d.push = 1'b0;
        d_d.pop = 1'b0;
        d_d.pc_load = 1'b0;
        // Each action is registered one clock early so it shows in its own quarter
        if (ph.q[`EXT_Q1]) begin
            d_d.op = OP_NONE;
            d_d.nop_next = 1'b0;
            if (dec_q1) begin
                if (i_instr[15:8] == `EXT_ADD_PTR_OPC) begin
                    d_d.sel = i_instr[`EXT_SEL_MSB:`EXT_SEL_LSB];
                    d_d.lit = i_instr[`EXT_LIT_MSB:0];
                    d_d.op = (i_instr[`EXT_SEL_MSB:`EXT_SEL_LSB] == `EXT_FRAME_SEL) ? OP_ADD_RET : OP_ADD_PTR;
                end else if (i_instr == `EXT_CALL_ACC_OPC) begin
                    d_d.op = OP_CALL_ACC;
                end
            end
        end
        if (ph.q[`EXT_Q2]) begin
            case (q_q.sel)
                2'h0: d_d.base = i_file_select_pointer_0;
                2'h1: d_d.base = i_file_select_pointer_1;
                default: d_d.base = i_stack_frame_pointer;
            endcase
            d_d.acc = i_accumulator_reg;
            if (q_q.op == OP_CALL_ACC) begin
                d_d.push = 1'b1;
                d_d.push_addr = PC_W'(i_pc + PC_W'(`EXT_RET_STEP));
            end
        end
        if (ph.q[`EXT_Q3]) begin
            case (q_q.op)
                OP_ADD_PTR, OP_ADD_RET: begin
                    d_d.ptr_we = 1'b1;
                    d_d.ptr_sel = (q_q.op == OP_ADD_RET) ? `EXT_FRAME_IDX : q_q.sel;
                    d_d.ptr_data = PTR_W'(q_q.base + PTR_W'(q_q.lit));
                    if (q_q.op == OP_ADD_RET) begin
                        d_d.pop = 1'b1;
                        d_d.pc_load = 1'b1;
                        d_d.pc_value = i_top_of_return_stack;
                        d_d.nop_next = 1'b1;
                    end
                end
                OP_CALL_ACC: begin
                    // Only the return address was saved; no shadow registers here
                    d_d.pc_load = 1'b1;
                    d_d.pc_value = {i_counter_latch_upper, i_counter_latch_high, q_q.acc};
                    d_d.nop_next = 1'b1;
                end
                default: d_d.nop_next = q_q.nop_next;
            endcase
        end
        if (ph.q[`EXT_Q4]) begin
            // Raised on the Q4 edge so the flag covers Q1 through Q4 of the idle cycle
            d_d.nop_cycle = q_q.nop_next;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            q_q <= '0;
        end else begin
            q_q <= d_d;
        end
    end

    assign o_ptr_we = q_q.ptr_we;
    assign o_ptr_sel = q_q.ptr_sel;
    assign o_ptr_data = q_q.ptr_data;
    assign o_stack_push = q_q.push;
    assign o_stack_push_addr = q_q.push_addr;
    assign o_stack_pop = q_q.pop;
    assign o_pc_load = q_q.pc_load;
    assign o_pc_value = q_q.pc_value;
    assign o_nop_cycle = q_q.nop_cycle;
    assign o_quarter = ph.q;

    // Checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_arst_n);

    logic dec_add;
    logic dec_ret;
    logic dec_call;
    assign dec_add = dec_q1 && i_instr[15:8] == `EXT_ADD_PTR_OPC && i_instr[7:6] != `EXT_FRAME_SEL;
    assign dec_ret = dec_q1 && i_instr[15:8] == `EXT_ADD_PTR_OPC && i_instr[7:6] == `EXT_FRAME_SEL;
    assign dec_call = dec_q1 && i_instr == `EXT_CALL_ACC_OPC;

    a_add_ptr_sel: assert property (dec_add |-> ##3 o_ptr_we && o_ptr_sel == $past(i_instr[7:6], 3))
        else $error("pointer add wrote wrong pointer or late");
    a_ret_frame_pop: assert property (dec_ret |-> ##3 o_ptr_we && o_ptr_sel == 2'h2 && o_stack_pop && o_pc_load
        && o_pc_value == $past(i_top_of_return_stack, 1))
        else $error("add-and-return did not update frame pointer and return");
    a_ret_nop_cycle: assert property (dec_ret |-> ##4 (o_nop_cycle && !o_ptr_we && !o_pc_load)[*4])
        else $error("add-and-return second cycle not idle");
    a_call_push_addr: assert property (dec_call |-> ##2 o_stack_push
        && o_stack_push_addr == PC_W'($past(i_pc, 1) + PC_W'(2)))
        else $error("call pushed wrong return address");
    a_call_low_byte: assert property (dec_call |-> ##3 o_pc_load && o_pc_value[7:0] == $past(i_accumulator_reg, 2))
        else $error("call low byte not from accumulator");
    a_call_high_bytes: assert property (dec_call |-> ##3 o_pc_value[PC_W-1:8]
        == {$past(i_counter_latch_upper, 1), $past(i_counter_latch_high, 1)})
        else $error("call high bytes not from latches");
    a_call_nop_cycle: assert property (dec_call |-> ##4 o_nop_cycle[*4])
        else $error("call second cycle not a no-operation");
    a_call_no_save: assert property (dec_call |-> ##1 (!o_ptr_we && !o_stack_pop)[*4])
        else $error("call touched state beyond the return address");
    a_disabled_idle: assert property (ph.q[0] && i_instr_valid && !i_extended_set_enable_bit
        |-> ##1 (!o_ptr_we && !o_stack_push && !o_pc_load)[*4])
        else $error("extended instruction ran while disabled");
    a_frame_carry: assert property (dec_ret |-> ##3 o_ptr_data
        == PTR_W'($past(i_stack_frame_pointer, 2) + PTR_W'($past(i_instr[5:0], 3))))
        else $error("frame pointer sum wrong");
    a_write_in_q4: assert property (o_ptr_we |-> ph.q[3])
        else $error("pointer written outside Q4");

    // Strobe placement and the forced idle cycle
    a_nop_refuse: assert property (o_nop_cycle && ph.q[`EXT_Q1] |-> ##3 !o_ptr_we && !o_pc_load)
        else $error("word taken during forced idle cycle");
    a_nop_starts_q1: assert property ($rose(o_nop_cycle) |-> ph.q[`EXT_Q1])
        else $error("idle cycle flag not aligned to Q1");
    a_nop_quiet: assert property (o_nop_cycle |-> !o_stack_push && !o_stack_pop && !o_ptr_we)
        else $error("activity during forced idle cycle");
    a_ret_frame_only: assert property (o_stack_pop |-> o_ptr_we && o_ptr_sel == 2'h2)
        else $error("return without frame pointer write");
    a_pop_with_load: assert property (o_stack_pop |-> o_pc_load)
        else $error("stack popped without counter load");
    a_load_pulse: assert property (o_pc_load |=> !o_pc_load)
        else $error("counter load longer than one clock");
    a_push_in_q3: assert property (o_stack_push |-> ph.q[`EXT_Q3])
        else $error("return address pushed outside Q3");
    a_push_pulse: assert property (o_stack_push |=> !o_stack_push)
        else $error("push longer than one clock");
    a_push_before_load: assert property (dec_call |-> ##2 o_stack_push && !o_pc_load
        ##1 !o_stack_push && o_pc_load)
        else $error("call loaded counter before push");
    a_load_in_q4: assert property (o_pc_load |-> ph.q[`EXT_Q4])
        else $error("counter loaded outside Q4");
    a_add_no_flow: assert property (dec_add |-> ##1
        (!o_stack_push && !o_stack_pop && !o_pc_load && !o_nop_cycle)[*4])
        else $error("pointer add disturbed program flow");
    a_ptr_we_pulse: assert property (o_ptr_we |=> !o_ptr_we)
        else $error("pointer write longer than one clock");

    c_add_ptr: cover property (dec_add ##3 o_ptr_we);
    c_add_ret: cover property (dec_ret ##4 o_nop_cycle);
    c_call_acc: cover property (dec_call ##3 o_pc_load);
    c_disabled: cover property (ph.q[0] && i_instr_valid && !i_extended_set_enable_bit);
    c_nop_refused: cover property (o_nop_cycle && ph.q[`EXT_Q1] && i_instr_valid);
endmodule
`default_nettype wire

// *** rtl/ext_exec_regs.svh ***
// Opcodes, field positions and phase indices for the extended-instruction execute block
`ifndef EXT_EXEC_REGS_SVH
`define EXT_EXEC_REGS_SVH

`define EXT_ADD_PTR_OPC 8'he8
`define EXT_CALL_ACC_OPC 16'h0014
`define EXT_SEL_MSB 7
`define EXT_SEL_LSB 6
`define EXT_LIT_MSB 5
`define EXT_FRAME_SEL 2'h3
`define EXT_FRAME_IDX 2'h2
`define EXT_RET_STEP 2
`define EXT_Q1 0
`define EXT_Q2 1
`define EXT_Q3 2
`define EXT_Q4 3

`endif

// *** rtl/ext_exec_pkg.sv ***
// Types shared by the extended-instruction execute block
`default_nettype none
package ext_exec_pkg;
    typedef enum logic [1:0] {
        OP_NONE = 2'b00,
        OP_ADD_PTR = 2'b01,
        OP_ADD_RET = 2'b10,
        OP_CALL_ACC = 2'b11
    } op_e;
    typedef logic [3:0] quarter_t;
endpackage
`default_nettype wire

// *** rtl/quarter_if.sv ***
// Quarter-phase carrier between the phase generator and the execute logic
`default_nettype none
interface quarter_if;
    import ext_exec_pkg::*;
    quarter_t q;
    modport src (output q);
    modport snk (input q);
endinterface
`default_nettype wire

// *** rtl/quarter_gen.sv ***
// Splits the core clock into four one-hot quarter phases
`default_nettype none
module quarter_gen (
    // Clock and reset
    input wire logic i_ref_clk,
    input wire logic i_arst_n,
    // Phase out
    quarter_if.src ph
);
    import ext_exec_pkg::*;

    typedef struct packed {
        quarter_t q;
    } gen_s;

    gen_s q_q;
    gen_s d_d;

    always_comb begin
        d_d = q_q;
        d_d.q = {q_q.q[2:0], q_q.q[3]};
    end

    always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            q_q.q <= 4'h8;
        end else begin
            q_q <= d_d;
        end
    end

    assign ph.q = q_q.q;
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the extended-instruction execute block
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import ext_exec_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic vld = 1'b0;
    logic en = 1'b1;
    logic [15:0] ins = 16'h0000;
    logic [11:0] p0 = 12'h000, p1 = 12'h000, fp = 12'h000;
    logic [20:0] pc = 21'h000000, top_of_return_stack = 21'h000000;
    logic [7:0] acc = 8'h00, lh = 8'h00;
    logic [4:0] lu = 5'h00;
    logic we, push, pop, ld, nop;
    logic [1:0] sel;
    logic [11:0] pd;
    logic [20:0] pa, pv;
    quarter_t q;
    int fail_count = 0;
    int tests_run = 0;
    always #10 clk = ~clk;
    ext_exec i_ext_exec (.i_ref_clk(clk), .i_arst_n(rst_n), .i_instr_valid(vld), .i_instr(ins),
        .i_extended_set_enable_bit(en), .i_file_select_pointer_0(p0), .i_file_select_pointer_1(p1),
        .i_stack_frame_pointer(fp), .i_pc(pc), .i_top_of_return_stack(top_of_return_stack), .i_accumulator_reg(acc),
        .i_counter_latch_high(lh), .i_counter_latch_upper(lu), .o_ptr_we(we), .o_ptr_sel(sel),
        .o_ptr_data(pd), .o_stack_push(push), .o_stack_push_addr(pa), .o_stack_pop(pop),
        .o_pc_load(ld), .o_pc_value(pv), .o_nop_cycle(nop), .o_quarter(q));
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, s, e);
        end
    endtask
    task automatic report_and_stop;
        if (fail_count == 0 && tests_run > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // Presents one word across a Q1 clock
    task automatic issue(input logic [15:0] w, input logic e);
        int n;
        n = 0;
        @(negedge clk);
        while (q !== 4'h1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        if (n == 8) begin
            fail_count++;
            report_and_stop();
        end
        ins = w;
        vld = 1'b1;
        en = e;
        @(negedge clk);
        vld = 1'b0;
        en = 1'b1;
    endtask
    task automatic await_sig(input bit use_push);
        int n;
        n = 0;
        while ((use_push ? push : we) !== 1'b1 && n < 8) begin
            @(negedge clk);
            n++;
        end
        if (n == 8) begin
            fail_count++;
            report_and_stop();
        end
    endtask
    // Offers a word in every clock of the forced idle cycle; none may be taken
    task automatic nop_check;
        int nops, hits;
        nops = 0;
        hits = 0;
        ins = 16'he805;
        repeat (10) begin
            @(negedge clk);
            vld = (nop === 1'b1);
            if (nop === 1'b1) nops++;
            if (we !== 1'b0) hits++;
        end
        vld = 1'b0;
        chk(nops, 4);
        chk(hits, 0);
    endtask
    task automatic s_add;
        logic [11:0] b[3];
        logic [5:0] k[3];
        b = '{12'hfff, 12'h3ff, 12'h7c1};
        k = '{6'h3f, 6'h23, 6'h00};
        p0 = b[0];
        p1 = b[1];
        fp = b[2];
        for (int f = 0; f < 3; f++) begin
            issue({8'he8, f[1:0], k[f]}, 1'b1);
            await_sig(1'b0);
            chk(q, 4'h8);
            chk(sel, f[1:0]);
            chk(pd, 12'(b[f] + 12'(k[f])));
            chk(ld | pop | push, 0);
        end
    endtask
    task automatic s_ret;
        p0 = 12'h111;
        p1 = 12'h222;
        fp = 12'h3ff;
        top_of_return_stack = 21'h1abcd;
        issue(16'he8e3, 1'b1);
        await_sig(1'b0);
        chk(sel, 2);
        chk(pd, 12'h422);
        chk({pop, ld}, 2'h3);
        chk(pv, 21'h1abcd);
        nop_check();
    endtask
    task automatic s_call;
        pc = 21'h000100;
        acc = 8'h06;
        lh = 8'h10;
        lu = 5'h1f;
        issue(16'h0014, 1'b1);
        await_sig(1'b1);
        chk(pa, 21'h000102);
        chk(ld, 0);
        @(negedge clk);
        chk(ld, 1);
        chk(pv, 21'h1f1006);
        chk(we | pop, 0);
        nop_check();
    endtask
    // Disabled set, a near-miss call code and a subtract word must all stay silent
    task automatic s_off;
        logic [15:0] w[3];
        logic e[3];
        int hits;
        w = '{16'he805, 16'h0015, 16'he905};
        e = '{1'b0, 1'b1, 1'b1};
        for (int i = 0; i < 3; i++) begin
            issue(w[i], e[i]);
            hits = 0;
            repeat (8) begin
                @(negedge clk);
                if ((we | push | pop | ld) !== 1'b0) hits++;
            end
            chk(hits, 0);
        end
    endtask
    // Cuts a call short with reset; the first Q1 after release must take a fresh word
    task automatic s_reset;
        p0 = 12'h0f0;
        issue(16'h0014, 1'b1);
        await_sig(1'b1);
        rst_n = 1'b0;
        #1;
        chk({we, push, pop, ld, nop}, 5'h00);
        chk(q, 4'h8);
        @(negedge clk);
        rst_n = 1'b1;
        issue(16'he805, 1'b1);
        await_sig(1'b0);
        chk(pd, 12'h0f5);
        chk(ld | pop, 0);
    endtask
    initial begin
        repeat (20) @(negedge clk);
        rst_n = 1'b1;
        s_add();
        s_ret();
        s_call();
        s_off();
        s_reset();
        report_and_stop();
    end
endmodule
`default_nettype wire
